// ==== rtl/sbci_device.sv ====
// SDRAM device end: command decode, banks, mode register, burst engine and data path
// Behaviour
// - Sample inputs and launch outputs on rising clock
// - Burst counter steps once per clock
// - Clock enable low masks the next edge
// - Idle banks plus clock enable low: power-down
// - Chip select high means no command
// - Controller may tie chip select low
// - Decode command from strobes and chip select
// - Eleven row bits, eight column bits
// - Four banks of 512K 32-bit words
// - Bank select picks target for each command; precharge all, mode register set and burst stop ignore it
// - Write data stored at edge after command
// - Read data as written, held one clock
// - Mask writes same clock, reads two later
// - Each mask bit governs one byte lane
// - Burst length 1, 2, 4, 8, aligned
// - New access truncates burst; precharge ends it
// - Controller masks reads before turning to write; sbci_host only drives the mask given in each command word
// - Interleave for 2/4/8; full page sequential
// - Sequential order adds one, wraps in window
// - Interleaved order XORs start with step
// - Full-page single-write: auto-precharge on writes only
// - Mode fields loaded from address bus
// - Burst stop ends burst, bank stays active
`timescale 1ns/1ps
module sbci_device #(
    parameter int ROWS_W = sbci_pkg::ROW_W,
    parameter int COLS_W = sbci_pkg::COL_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    sbci_if.dev pin,
    output logic power_down_o,
    output logic [sbci_pkg::NBANK-1:0] bank_open_o,
    output logic burst_busy_o,
    output logic [sbci_pkg::ADDR_W-1:0] mode_o
);
    import sbci_pkg::*;

    typedef enum logic [1:0] {
        BURST_IDLE = 2'b00,
        BURST_RD = 2'b01,
        BURST_WR = 2'b10
    } sbci_burst_e;

    localparam int MEM_AW = BANK_W + ROWS_W + COLS_W;

    logic [DATA_W-1:0] mem [2**MEM_AW];
    logic cke_q;
    logic pd_q;
    logic [ADDR_W-1:0] mode_q;
    logic [NBANK-1:0] open_q;
    logic [ROWS_W-1:0] row_q [NBANK];
    sbci_burst_e state_q;
    logic [BANK_W-1:0] bank_q;
    logic [COLS_W-1:0] start_q;
    logic [COLS_W-1:0] step_q;
    logic [COLS_W:0] left_q;
    logic full_q;
    logic ap_q;
    logic [MASK_W-1:0] dqm_q;
    logic [MASK_W-1:0] dqm2_q;
    logic [DATA_W-1:0] pipe_q;
    logic pipe_vld_q;
    logic [DATA_W-1:0] dq_q;
    logic vld_q;

    logic live;
    sbci_cmd_e cmd;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] ad;
    logic is_acc;
    logic is_cut;
    logic [COLS_W-1:0] blen_mask;
    logic [COLS_W:0] blen;
    logic full_bl;
    logic step_en;
    logic last;
    logic [COLS_W-1:0] col;
    logic [MEM_AW-1:0] idx;
    logic [DATA_W-1:0] rd_word;
    logic cl3;

    ////////////////////////////////////////////////////////////////////////////
    // Clock enable history: an edge after a low sample decodes no command and steps no burst
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cke_q <= 1'b1;
        end else begin
            cke_q <= pin.cke;
        end
    end

    // Command decode: strobes and chip select from this edge, clock enable from the edge before
    always_comb begin
        live = cke_q;
        ba = {pin.bank_select_hi, pin.bank_select_lo};
        ad = pin.multiplexed_address_bus;
        if (!live || pin.cs_n) begin
            cmd = nop_cmd;
        end else begin
            cmd = sbci_cmd_e'({pin.ras_n, pin.cas_n, pin.we_n});
        end
        is_acc = (cmd == read_cmd) || (cmd == write_cmd);
        is_cut = is_acc || (cmd == burst_stop_cmd) || (cmd == precharge_cmd);
    end

    // Burst window from the mode register
    always_comb begin
        full_bl = (mode_q[MR_BL_LSB +: MR_BL_W] == BL_FULL);
        if (full_bl) begin
            blen_mask = '1;
        end else begin
            blen_mask = COLS_W'((1 << mode_q[MR_BL_LSB +: 2]) - 1);
        end
        blen = {1'b0, blen_mask} + (COLS_W+1)'(1);
        cl3 = (mode_q[MR_CL_LSB +: MR_CL_W] == CL_THREE);
        step_en = live && (state_q != BURST_IDLE) && !is_cut;
        last = !full_q && (left_q == (COLS_W+1)'(1));
    end

    sbci_burst_addr #(
        .COLS_W(COLS_W)
    ) u_addr (
        .start_i(start_q),
        .step_i(step_q),
        .mask_i(full_q ? '1 : blen_mask),
        .interleave_i(mode_q[MR_BT_BIT] && !full_q),
        .col_o(col)
    );

    assign idx = {bank_q, row_q[bank_q], col};
    assign rd_word = mem[idx];

    ////////////////////////////////////////////////////////////////////////////
    // Mode register, only while every bank is closed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= MODE_RST;
        end else if (cmd == mode_register_set_cmd && open_q == '0) begin
            mode_q <= ad;
        end
    end

    // Bank open state and latched rows
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            open_q <= '0;
            for (int b = 0; b < NBANK; b++) begin
                row_q[b] <= '0;
            end
        end else begin
            if (step_en && last && ap_q) begin
                open_q[bank_q] <= 1'b0;
            end
            if (cmd == bank_activate_cmd) begin
                open_q[ba] <= 1'b1;
                row_q[ba] <= ad[ROWS_W-1:0];
            end else if (cmd == precharge_cmd) begin
                if (ad[AP_BIT]) begin
                    open_q <= '0;
                end else begin
                    open_q[ba] <= 1'b0;
                end
            end
        end
    end

    // Power-down entry needs idle banks and no burst
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pd_q <= 1'b0;
        end else if (pin.cke) begin
            pd_q <= 1'b0;
        end else if (open_q == '0 && state_q == BURST_IDLE) begin
            pd_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst engine: a new access restarts, stop or precharge ends
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= BURST_IDLE;
            bank_q <= '0;
            start_q <= '0;
            step_q <= '0;
            left_q <= '0;
            full_q <= 1'b0;
            ap_q <= 1'b0;
        end else if (is_acc) begin
            state_q <= (cmd == write_cmd) ? BURST_WR : BURST_RD;
            bank_q <= ba;
            start_q <= ad[COLS_W-1:0];
            step_q <= '0;
            full_q <= full_bl;
            // Single-write mode forces one word on writes
            if (cmd == write_cmd && ad[MR_WB_BIT - MR_WB_BIT] == 1'b0 && mode_q[MR_WB_BIT]) begin
                left_q <= (COLS_W+1)'(1);
                full_q <= 1'b0;
            end else if (cmd == write_cmd && mode_q[MR_WB_BIT]) begin
                left_q <= (COLS_W+1)'(1);
                full_q <= 1'b0;
            end else begin
                left_q <= blen;
            end
            // Full page honours auto-precharge only on single writes
            ap_q <= ad[AP_BIT] && (!full_bl || (cmd == write_cmd && mode_q[MR_WB_BIT]));
        end else if (cmd == burst_stop_cmd || cmd == precharge_cmd) begin
            state_q <= BURST_IDLE;
        end else if (step_en) begin
            step_q <= step_q + COLS_W'(1);
            if (!full_q) begin
                left_q <= left_q - (COLS_W+1)'(1);
            end
            if (last) begin
                state_q <= BURST_IDLE;
            end
        end
    end

    // Array write, one edge after the command, per byte lane
    always_ff @(posedge clk_i) begin
        if (step_en && state_q == BURST_WR) begin
            for (int i = 0; i < MASK_W; i++) begin
                if (!pin.dqm[i]) begin
                    mem[idx][i*LANE_W +: LANE_W] <= pin.dq[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path: one extra stage for latency three; mask lags by two edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dqm_q <= '1;
            dqm2_q <= '1;
            pipe_q <= '0;
            pipe_vld_q <= 1'b0;
            dq_q <= '0;
            vld_q <= 1'b0;
        end else begin
            dqm_q <= pin.dqm;
            dqm2_q <= dqm_q; // Second stage: word sampled two edges after the mask
            if (cmd == burst_stop_cmd || cmd == precharge_cmd) begin
                pipe_vld_q <= 1'b0; // Read cut short leaves the bus undriven
                vld_q <= 1'b0;
            end else if (live) begin
                pipe_q <= rd_word;
                pipe_vld_q <= step_en && state_q == BURST_RD;
                dq_q <= cl3 ? pipe_q : rd_word;
                vld_q <= cl3 ? pipe_vld_q : (step_en && state_q == BURST_RD);
            end
        end
    end

    // Outputs all from flip-flops on the same clock
    assign pin.dev_dq = dq_q;
    assign pin.dev_dq_oe = {MASK_W{vld_q}} & ~dqm2_q;
    assign power_down_o = pd_q;
    assign bank_open_o = open_q;
    assign burst_busy_o = (state_q != BURST_IDLE);
    assign mode_o = mode_q;
endmodule

// ==== rtl/sbci_pkg.sv ====
// Shared constants, command codes and register map for the SDRAM command interface
package sbci_pkg;
    // Array geometry
    localparam int ROW_W = 11;
    localparam int COL_W = 8;
    localparam int BANK_W = 2;
    localparam int NBANK = 4;
    localparam int DATA_W = 32;
    localparam int MASK_W = 4;
    localparam int LANE_W = 8;
    localparam int ADDR_W = 11;
    // Strobe code {ras_n, cas_n, we_n} with chip select low
    typedef enum logic [2:0] {
        mode_register_set_cmd = 3'b000,
        refresh_cmd = 3'b001,
        precharge_cmd = 3'b010,
        bank_activate_cmd = 3'b011,
        write_cmd = 3'b100,
        read_cmd = 3'b101,
        burst_stop_cmd = 3'b110,
        nop_cmd = 3'b111
    } sbci_cmd_e;
    // Mode register fields on the address bus
    localparam int MR_BL_LSB = 0;
    localparam int MR_BL_W = 3;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_CL_W = 3;
    localparam int MR_WB_BIT = 9;
    localparam int AP_BIT = 10;
    localparam logic [MR_BL_W-1:0] BL_FULL = 3'h7;
    localparam logic [MR_CL_W-1:0] CL_THREE = 3'h3;
    localparam logic [ADDR_W-1:0] MODE_RST = 11'h020;
    // Controller register map (byte addresses)
    localparam int AV_AW = 5;
    localparam logic [AV_AW-1:0] REG_CTRL = 5'h00;
    localparam logic [AV_AW-1:0] REG_CMD = 5'h04;
    localparam logic [AV_AW-1:0] REG_WDATA = 5'h08;
    localparam logic [AV_AW-1:0] REG_RDATA = 5'h0C;
    localparam logic [AV_AW-1:0] REG_STAT = 5'h10;
    localparam int CTRL_CKE_BIT = 0;
    localparam int CTRL_DESEL_BIT = 1;
    localparam int CTRL_CL_LSB = 2;
    localparam int CMD_BA_LSB = 3;
    localparam int CMD_ADDR_LSB = 5;
    localparam int CMD_DQM_LSB = 16;
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000000D;
endpackage

// ==== rtl/sbci_if.sv ====
// Pin bundle between the SDRAM device end and its controller end
`timescale 1ns/1ps
interface sbci_if;
    import sbci_pkg::*;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bank_select_lo;
    logic bank_select_hi;
    logic [ADDR_W-1:0] multiplexed_address_bus;
    logic [MASK_W-1:0] dqm;
    logic [DATA_W-1:0] host_dq;
    logic host_dq_oe;
    logic [DATA_W-1:0] dev_dq;
    logic [MASK_W-1:0] dev_dq_oe;
    logic [DATA_W-1:0] dq;

    // Per lane, the device wins; an undriven lane reads as zero
    always_comb begin
        for (int i = 0; i < MASK_W; i++) begin
            dq[i*LANE_W +: LANE_W] = dev_dq_oe[i] ? dev_dq[i*LANE_W +: LANE_W] :
                                     host_dq_oe ? host_dq[i*LANE_W +: LANE_W] : 8'h00;
        end
    end

    modport dev (input cke, cs_n, ras_n, cas_n, we_n, bank_select_lo, bank_select_hi,
                 multiplexed_address_bus, dqm, dq, output dev_dq, dev_dq_oe);
    modport host (output cke, cs_n, ras_n, cas_n, we_n, bank_select_lo, bank_select_hi,
                  multiplexed_address_bus, dqm, host_dq, host_dq_oe, input dq);
endinterface

// ==== rtl/sbci_burst_addr.sv ====
// Burst column generator: sequential or interleaved order inside an aligned window
`timescale 1ns/1ps
module sbci_burst_addr #(
    parameter int COLS_W = sbci_pkg::COL_W
) (
    input wire logic [COLS_W-1:0] start_i,
    input wire logic [COLS_W-1:0] step_i,
    input wire logic [COLS_W-1:0] mask_i,
    input wire logic interleave_i,
    output logic [COLS_W-1:0] col_o
);
    import sbci_pkg::*;
    logic [COLS_W-1:0] low;

    // Low bits walk, high bits stay as latched with the command
    always_comb begin
        low = interleave_i ? (start_i ^ step_i) : COLS_W'(start_i + step_i);
        col_o = (start_i & ~mask_i) | (low & mask_i);
    end
endmodule

// ==== rtl/sbci_host.sv ====
// Controller end: Avalon-MM registers turned into SDRAM pin commands
`timescale 1ns/1ps
module sbci_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [sbci_pkg::AV_AW-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [sbci_pkg::DATA_W-1:0] avs_writedata_i,
    output logic [sbci_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    sbci_if.host pin
);
    import sbci_pkg::*;

    logic ack_q;
    logic [DATA_W-1:0] ctrl_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] rdata_q;
    logic rvalid_q;
    logic [DATA_W-1:0] rd_q;
    logic go_q;
    logic [2:0] code_q;
    logic [BANK_W-1:0] ba_q;
    logic [ADDR_W-1:0] ad_q;
    logic [MASK_W-1:0] dqm_q;
    logic wr_oe_q;
    logic [3:0] cnt_q;
    logic wr_take;
    logic rd_take;
    logic cmd_take;
    logic capture;

    ////////////////////////////////////////////////////////////////////////////
    // One wait cycle per access keeps the slave simple
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_i || avs_write_i) && !ack_q;
        end
    end
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
    assign wr_take = avs_write_i && ack_q;
    assign rd_take = avs_read_i && ack_q;
    assign cmd_take = wr_take && avs_address_i == REG_CMD;
    assign capture = (cnt_q == 4'h1);

    // Read data loaded one edge before the accepting edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_q <= '0;
        end else if (avs_read_i && !ack_q) begin
            unique case (avs_address_i)
                REG_CTRL: rd_q <= ctrl_q;
                REG_WDATA: rd_q <= wdata_q;
                REG_RDATA: rd_q <= rdata_q;
                REG_STAT: rd_q <= {30'h0, (cnt_q != 4'h0), rvalid_q};
                default: rd_q <= '0;
            endcase
        end
    end
    assign avs_readdata_o = rd_q;

    // Writable registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
            wdata_q <= '0;
        end else if (wr_take && avs_address_i == REG_CTRL) begin
            ctrl_q <= avs_writedata_i;
        end else if (wr_take && avs_address_i == REG_WDATA) begin
            wdata_q <= avs_writedata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command word becomes one pin cycle; mask stays until the next command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            go_q <= 1'b0;
            code_q <= nop_cmd;
            ba_q <= '0;
            ad_q <= '0;
            dqm_q <= '1;
        end else begin
            go_q <= cmd_take;
            if (cmd_take) begin
                code_q <= avs_writedata_i[2:0];
                ba_q <= avs_writedata_i[CMD_BA_LSB +: BANK_W];
                ad_q <= avs_writedata_i[CMD_ADDR_LSB +: ADDR_W];
                dqm_q <= avs_writedata_i[CMD_DQM_LSB +: MASK_W];
            end
        end
    end

    // Deselect only on request; otherwise chip select held low
    assign pin.cke = ctrl_q[CTRL_CKE_BIT];
    assign pin.cs_n = go_q ? 1'b0 : ctrl_q[CTRL_DESEL_BIT];
    assign {pin.ras_n, pin.cas_n, pin.we_n} = go_q ? code_q : 3'b111;
    assign {pin.bank_select_hi, pin.bank_select_lo} = ba_q;
    assign pin.multiplexed_address_bus = ad_q;
    assign pin.dqm = dqm_q;

    ////////////////////////////////////////////////////////////////////////////
    // Write data driven for the edge after the write command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_oe_q <= 1'b0;
        end else begin
            wr_oe_q <= go_q && code_q == write_cmd;
        end
    end
    assign pin.host_dq = wdata_q;
    assign pin.host_dq_oe = wr_oe_q;

    // Read capture after the programmed latency; capture beats software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else begin
            if (go_q && code_q == read_cmd) begin
                cnt_q <= 4'(ctrl_q[CTRL_CL_LSB +: 2]);
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
            if (capture) begin
                rdata_q <= pin.dq;
                rvalid_q <= 1'b1;
            end else if (rd_take && avs_address_i == REG_RDATA) begin
                rvalid_q <= 1'b0;
            end
        end
    end
endmodule

// ==== testbench/sbci_props.sv ====
// Pin-level checks between the SDRAM device end and the controller end
`timescale 1ns/1ps
module sbci_props
    import sbci_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bank_select_lo,
    input wire logic bank_select_hi,
    input wire logic [ADDR_W-1:0] multiplexed_address_bus,
    input wire logic [MASK_W-1:0] dqm,
    input wire logic host_dq_oe,
    input wire logic [MASK_W-1:0] dev_dq_oe,
    input wire logic power_down_o,
    input wire logic [NBANK-1:0] bank_open_o,
    input wire logic burst_busy_o,
    input wire logic [ADDR_W-1:0] mode_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Decode only counts when the previous clock enable sample was high
    logic cke_q;
    logic live;
    logic [2:0] code;
    always_ff @(posedge clk_i) begin
        cke_q <= rst_i ? 1'h1 : cke;
    end
    assign live = !cs_n && cke_q;
    assign code = {ras_n, cas_n, we_n};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////
    // Command effects, tied to the exact edge
    open_bank_a: assert property (live && code == bank_activate_cmd
        |=> bank_open_o[$past({bank_select_hi, bank_select_lo})])
        else $error("activate left the addressed bank closed");
    desel_quiet_a: assert property (cs_n |=> (bank_open_o & ~$past(bank_open_o)) == 4'h0)
        else $error("bank opened while chip select was high");
    mode_load_a: assert property (live && code == mode_register_set_cmd && bank_open_o == 4'h0
        |=> mode_o == $past(multiplexed_address_bus))
        else $error("mode register not loaded from the address bus");
    stop_ends_a: assert property (live && code == burst_stop_cmd
        |=> !burst_busy_o && bank_open_o == $past(bank_open_o))
        else $error("burst stop left a burst running or closed a bank");
    pre_all_a: assert property (live && code == precharge_cmd
        && multiplexed_address_bus[AP_BIT] |=> bank_open_o == 4'h0)
        else $error("precharge all left a bank open");
    // Read path: latency three, mask two clocks later, no fight on the bus
    read_lat_a: assert property (live && code == read_cmd && dqm == 4'h0
        && mode_o[MR_CL_LSB +: MR_CL_W] == CL_THREE |-> ##3 dev_dq_oe == 4'hF)
        else $error("first read word not driven three clocks after read");
    read_mask_a: assert property (|dev_dq_oe |-> (dev_dq_oe & $past(dqm, 2)) == 4'h0)
        else $error("read lane driven although masked two clocks before");
    bus_turn_a: assert property (host_dq_oe |-> dev_dq_oe == 4'h0)
        else $error("both ends drive the data bus");
    // Power-down only from an idle device with clock enable low
    pdown_entry_a: assert property ((!cke && bank_open_o == 4'h0 && !burst_busy_o) [*2]
        |-> ##[0:2] power_down_o)
        else $error("idle device with clock enable low not in power-down");
    pdown_idle_a: assert property (power_down_o |-> bank_open_o == 4'h0 && !burst_busy_o)
        else $error("power-down with a bank open or a burst running");
    rd_c: cover property (live && code == read_cmd);
    mrs_c: cover property (live && code == mode_register_set_cmd);
    stop_c: cover property (live && code == burst_stop_cmd);
    pd_c: cover property ($rose(power_down_o));
endmodule

// ==== testbench/test_sdram_burst_command_interface.sv ====
// Bench joining both ends and driving the controller over Avalon-MM
`timescale 1ns/1ps
module test_sdram_burst_command_interface;
    import sbci_pkg::*;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic [AV_AW-1:0] avs_address_i = '0;
    logic avs_read_i = 1'h0;
    logic avs_write_i = 1'h0;
    logic [DATA_W-1:0] avs_writedata_i = '0;
    logic [DATA_W-1:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic power_down_o;
    logic [NBANK-1:0] bank_open_o;
    logic burst_busy_o;
    logic [ADDR_W-1:0] mode_o;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    sbci_if pin ();
    sbci_device u_sbci_device (.clk_i(clk_i), .rst_i(rst_i), .pin(pin),
        .power_down_o(power_down_o), .bank_open_o(bank_open_o),
        .burst_busy_o(burst_busy_o), .mode_o(mode_o));
    sbci_host u_sbci_host (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .pin(pin));
    sbci_props u_sbci_props (.clk_i(clk_i), .rst_i(rst_i), .cke(pin.cke), .cs_n(pin.cs_n),
        .ras_n(pin.ras_n), .cas_n(pin.cas_n), .we_n(pin.we_n),
        .bank_select_lo(pin.bank_select_lo), .bank_select_hi(pin.bank_select_hi),
        .multiplexed_address_bus(pin.multiplexed_address_bus), .dqm(pin.dqm),
        .host_dq_oe(pin.host_dq_oe), .dev_dq_oe(pin.dev_dq_oe), .power_down_o(power_down_o),
        .bank_open_o(bank_open_o), .burst_busy_o(burst_busy_o), .mode_o(mode_o));
    ////////////////////////////////////////////////////////////////////////////
    // 40 MHz clock; the cycle ceiling cuts a hang short
    initial forever #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Avalon master: request held until waitrequest is seen low at an edge
    task automatic av(input logic wr_en, input logic [AV_AW-1:0] a,
                      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr_en;
        avs_read_i <= !wr_en;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'h0) @(posedge clk_i);
        q = avs_readdata_o;
        avs_write_i <= 1'h0;
        avs_read_i <= 1'h0;
    endtask
    task automatic wr(input logic [AV_AW-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] q;
        av(1'h1, a, d, q);
    endtask
    task automatic rdchk(input string what, input logic [AV_AW-1:0] a,
                         input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] q;
        av(1'h0, a, '0, q);
        check(what, q, exp);
    endtask
    task automatic cmd(input sbci_cmd_e c, input logic [1:0] ba, input logic [ADDR_W-1:0] ad,
                       input logic [MASK_W-1:0] m);
        wr(REG_CMD, {12'h000, m, ad, ba, c});
    endtask
    function automatic logic [DATA_W-1:0] pat(input logic [COL_W-1:0] c);
        return {24'hC0DE00, c};
    endfunction
    // Collects the words the device drives in the ten clocks after a read command
    task automatic burst(input logic [COL_W-1:0] col, input logic [MASK_W-1:0] m,
                         input logic [DATA_W-1:0] exp[4]);
        logic [DATA_W-1:0] q[$];
        cmd(read_cmd, 2'h1, ADDR_W'(col), m);
        repeat (10) begin
            @(negedge clk_i);
            if (pin.dev_dq_oe !== 4'h0) q.push_back(pin.dq);
        end
        check("burst length", 32'(q.size()), 32'h4);
        if (q.size() == 4) foreach (exp[k]) check("burst word", q[k], exp[k]);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        @(negedge clk_i);
        check("mode reset", 32'(mode_o), 32'(MODE_RST));
        check("banks reset", 32'(bank_open_o), 32'h0);
        rdchk("ctrl reset", REG_CTRL, CTRL_RST);
        rdchk("unmapped", 5'h1C, 32'h0);
        $display("test reset done");
    endtask
    // Single-write mode, four-word bursts, latency three; bank 2 holds a decoy
    task automatic t_fill();
        cmd(mode_register_set_cmd, 2'h0, 11'h232, 4'h0);
        repeat (2) @(negedge clk_i);
        check("mode load", 32'(mode_o), 32'h232);
        cmd(bank_activate_cmd, 2'h1, 11'h2AA, 4'h0);
        repeat (2) @(negedge clk_i);
        check("bank open", 32'(bank_open_o), 32'h2);
        for (int c = 4; c < 8; c++) begin
            wr(REG_WDATA, pat(8'(c)));
            cmd(write_cmd, 2'h1, 11'(c), 4'h0);
        end
        wr(REG_WDATA, 32'hFFFFFFFF);
        cmd(write_cmd, 2'h1, 11'h006, 4'h2);
        cmd(bank_activate_cmd, 2'h2, 11'h155, 4'h0);
        wr(REG_WDATA, 32'h0BAD0BAD);
        cmd(write_cmd, 2'h2, 11'h005, 4'h0);
        $display("test fill done");
    endtask
    task automatic t_seq();
        burst(8'h05, 4'h0, '{pat(8'h05), 32'hFFFF00FF, pat(8'h07), pat(8'h04)});
        rdchk("read valid", REG_STAT, 32'h1);
        rdchk("host capture", REG_RDATA, pat(8'h05));
        rdchk("valid cleared", REG_STAT, 32'h0);
        $display("test sequential done");
    endtask
    task automatic t_ilv();
        cmd(precharge_cmd, 2'h0, 11'h400, 4'h0);
        repeat (2) @(negedge clk_i);
        check("all closed", 32'(bank_open_o), 32'h0);
        cmd(mode_register_set_cmd, 2'h0, 11'h23A, 4'h0);
        cmd(bank_activate_cmd, 2'h1, 11'h2AA, 4'h0);
        burst(8'h05, 4'h8, '{32'h00DE0005, 32'h00DE0004, 32'h00DE0007,
            32'h00FF00FF});
        $display("test interleave done");
    endtask
    task automatic t_stop();
        cmd(read_cmd, 2'h1, 11'h004, 4'h0);
        cmd(burst_stop_cmd, 2'h1, 11'h000, 4'h0);
        repeat (2) @(negedge clk_i);
        check("stop idle", 32'(burst_busy_o), 32'h0);
        check("stop bank", 32'(bank_open_o), 32'h2);
        $display("test stop done");
    endtask
    // Deselected idle bus still lets commands through
    task automatic t_desel();
        wr(REG_CTRL, 32'h0000000F);
        @(negedge clk_i);
        check("idle deselect", 32'(pin.cs_n), 32'h1);
        cmd(bank_activate_cmd, 2'h3, 11'h011, 4'h0);
        repeat (2) @(negedge clk_i);
        check("open bank 3", 32'(bank_open_o), 32'hA);
        wr(REG_CTRL, CTRL_RST);
        $display("test deselect done");
    endtask
    task automatic t_pdown();
        cmd(precharge_cmd, 2'h0, 11'h400, 4'h0);
        wr(REG_CTRL, 32'h0000000C);
        repeat (4) @(negedge clk_i);
        check("power-down", 32'(power_down_o), 32'h1);
        wr(REG_CTRL, CTRL_RST);
        repeat (3) @(negedge clk_i);
        check("power-up", 32'(power_down_o), 32'h0);
        $display("test power-down done");
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        t_reset();
        t_fill();
        t_seq();
        t_ilv();
        t_stop();
        t_desel();
        t_pdown();
        results();
    end
endmodule
